// [sss_cfg.svh]
// constants of the supply start/stop sequencer
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH
// clock rate and time-to-cycle conversion
`define SSS_CLK_MHZ 250
`define SSS_CYC(us) ((us) * `SSS_CLK_MHZ)
// times in microseconds
`define SSS_T_RRST_US 5000
`define SSS_T_STOP_US 200
`define SSS_T_SHORT_US 100000
`define SSS_T_MS_US 1000
// off/hold time codes in milliseconds
`define SSS_SEL0_MS 1
`define SSS_SEL1_MS 4
`define SSS_SEL2_MS 8
`define SSS_SEL3_MS 16
// register indices, byte address is four times the index
`define SSS_IDX_HARD_RESET_REQUEST 6'h03
`define SSS_IDX_RESTART_REQUEST 6'h04
`define SSS_IDX_STATE 6'h05
`define SSS_IDX_IRQ_ST 6'h08
`define SSS_IDX_IRQ_MSK 6'h09
// field positions
`define SSS_GO_BIT 0
`define SSS_SEL_LSB 4
`define SSS_SEL_MSB 5
`define SSS_HIST_BIT 7
`define SSS_RUN_BIT 0
`define SSS_OTP_BIT 2
`define SSS_CLR_VAL 8'h00
// event bits
`define SSS_EV_UP 0
`define SSS_EV_DOWN 1
`define SSS_EV_SHORT 2
`define SSS_EV_OTP 3
`define SSS_EV_W 4
// pin synchroniser lanes
`define SSS_PIN_EN 0
`define SSS_PIN_SUP_HI 1
`define SSS_PIN_SUP_LO 2
`define SSS_PIN_OTP 3
`define SSS_PIN_SHORT 4
`define SSS_PIN_GATE_A 5
`define SSS_PIN_GATE_B 6
`define SSS_PIN_W 7
`endif

// [sss_host_model.sv]
// host processor model driving the enable and gate pins of the sequencer
`timescale 1ns/100ps
module sss_host_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic want_on,
	input  wire logic want_a,
	input  wire logic want_b,
	input  wire logic reset_out_first,
	input  wire logic reset_out_second,
	output logic      chip_enable_in,
	output logic      regulator_gate_in_a,
	output logic      regulator_gate_in_b,
	output logic      host_alive
);
	// port pins change just after the clock edge, like a processor output port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chip_enable_in      <= 1'b0;
			regulator_gate_in_a <= 1'b0;
			regulator_gate_in_b <= 1'b0;
		end else begin
			chip_enable_in      <= want_on;
			regulator_gate_in_a <= want_a;
			regulator_gate_in_b <= want_b;
		end
	end
	// the host only runs while both of its reset lines are released
	assign host_alive = reset_out_first & reset_out_second;
endmodule

// [sss_pkg.sv]
// types of the supply start/stop sequencer
package sss_pkg;
	typedef logic [31:0] sss_cnt_t;
	typedef enum logic [3:0] {
		ST_OFF    = 4'h0,
		ST_UP1    = 4'h1,
		ST_UP2    = 4'h2,
		ST_UP3    = 4'h3,
		ST_UP4    = 4'h4,
		ST_UP5    = 4'h5,
		ST_RUN    = 4'h6,
		ST_DN1    = 4'h7,
		ST_DN2    = 4'h8,
		ST_DN3    = 4'h9,
		ST_DN4    = 4'ha,
		ST_DN5    = 4'hb,
		ST_REWAIT = 4'hc
	} sss_state_e;
endpackage

// [sss_timer.sv]
// one-shot down counter, done is high in the last cycle of the delay
`timescale 1ns/100ps
module sss_timer import sss_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	sss_tmr_if.tmr   t
);
	sss_cnt_t cnt_q;
	logic     busy_q;

	// done marks the last of load cycles after start
	assign t.busy = busy_q;
	assign t.done = busy_q && (cnt_q == '0);

	// clear wins over start, start restarts a running delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			cnt_q  <= '0;
		end else if (t.clr) begin
			busy_q <= 1'b0;
		end else if (t.start) begin
			busy_q <= 1'b1;
			cnt_q  <= t.load - 32'h1;
		end else if (t.done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 32'h1;
		end
	end
endmodule

// [sss_tmr_if.sv]
// interface between the sequencer and a delay timer
`timescale 1ns/100ps
interface sss_tmr_if;
	import sss_pkg::*;
	logic     start;
	logic     clr;
	sss_cnt_t load;
	logic     busy;
	logic     done;
	modport ctl (output start, output clr, output load, input busy, input done);
	modport tmr (input start, input clr, input load, output busy, output done);
endinterface

// [sss_top.sv]
// supply start/stop sequencer with apb registers
// Functional notes
// - rails start only with the supply above the start level and the enable pin high.
// - rails stop when the supply falls to the stop level or the enable pin goes low.
// - a zero-to-one write of the restart bit runs the stop procedure.
// - over-temperature stops the rails whatever the other conditions are.
// - the running flag in the status register mirrors the running state.
// - each stop step waits the stop-step delay before the next one.
// - with both resets high the gate pins switch the linear regulators.
// - a short is declared only after the short input stays high for the qualification time.
// - the hard-reset register drives the second reset independently of start/stop.
// - a restart stops, waits the off time, starts again and clears its bit.
// - the off time is chosen by a two-bit field as 1, 4, 8 or 16 ms.
// - a hard reset holds the second reset low for the chosen time and clears its bit.
// - with both resets high and gate pin a low all linear regulators are off.
`timescale 1ns/100ps
`include "sss_cfg.svh"
module sss_top import sss_pkg::*; #(
	parameter int T_STEP_CYC  = `SSS_CYC(`SSS_T_STOP_US),
	parameter int T_RRST_CYC  = `SSS_CYC(`SSS_T_RRST_US),
	parameter int T_SHORT_CYC = `SSS_CYC(`SSS_T_SHORT_US),
	parameter int T_MS_CYC    = `SSS_CYC(`SSS_T_MS_US)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        chip_enable_in,
	input  wire logic        supply_above_start,
	input  wire logic        supply_below_stop,
	input  wire logic        overtemp_in,
	input  wire logic        output_short_in,
	input  wire logic        regulator_gate_in_a,
	input  wire logic        regulator_gate_in_b,
	output logic             buckboost_en,
	output logic      [1:0]  buck_en,
	output logic      [3:0]  ldo_en,
	output logic             reset_out_first,
	output logic             reset_out_second,
	output logic             irq
);
	// select time in cycles for a two-bit code
	function automatic sss_cnt_t sel_cyc(input logic [1:0] sel);
		unique case (sel)
			2'h0: sel_cyc = 32'(`SSS_SEL0_MS * T_MS_CYC);
			2'h1: sel_cyc = 32'(`SSS_SEL1_MS * T_MS_CYC);
			2'h2: sel_cyc = 32'(`SSS_SEL2_MS * T_MS_CYC);
			2'h3: sel_cyc = 32'(`SSS_SEL3_MS * T_MS_CYC);
		endcase
	endfunction

	// state lies in an inclusive range of codes
	function automatic logic in_rng(input sss_state_e s, input sss_state_e lo,
		input sss_state_e hi);
		in_rng = (s >= lo) && (s <= hi);
	endfunction

	logic [`SSS_PIN_W-1:0] pin_m_q;
	logic [`SSS_PIN_W-1:0] pin_s_q;
	sss_state_e            state_q;
	sss_state_e            state_d;
	logic [31:0]           prdata_q;
	logic                  pready_q;
	logic                  pslverr_q;
	logic                  hard_reset_request_q;
	logic [1:0]            hard_reset_request_sel_q;
	logic                  hard_reset_request_hist_q;
	logic                  restart_request_q;
	logic [1:0]            restart_request_sel_q;
	logic                  restart_request_hist_q;
	logic [`SSS_EV_W-1:0]  irq_st_q;
	logic [`SSS_EV_W-1:0]  irq_msk_q;
	logic                  irq_q;
	logic                  otp_prev_q;
	logic                  sc_seen_q;
	logic                  running_q;
	logic                  bb_q;
	logic                  bk_q;
	logic                  r1_q;
	logic                  r2_q;
	logic                  l4st_q;
	logic [3:0]            ldo_q;
	sss_tmr_if             seq_t ();
	sss_tmr_if             hold_t ();
	sss_tmr_if             sc_t ();

	// two flip-flops on every pin before any logic reads it
	wire [`SSS_PIN_W-1:0] pin_raw = {regulator_gate_in_b, regulator_gate_in_a,
		output_short_in, overtemp_in, supply_below_stop, supply_above_start,
		chip_enable_in};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_m_q <= '0;
			pin_s_q <= '0;
		end else begin
			pin_m_q <= pin_raw;
			pin_s_q <= pin_m_q;
		end
	end
	wire en_s     = pin_s_q[`SSS_PIN_EN];
	wire sup_hi_s = pin_s_q[`SSS_PIN_SUP_HI];
	wire sup_lo_s = pin_s_q[`SSS_PIN_SUP_LO];
	wire otp_s    = pin_s_q[`SSS_PIN_OTP];
	wire short_s  = pin_s_q[`SSS_PIN_SHORT];
	wire gate_a   = pin_s_q[`SSS_PIN_GATE_A];
	wire gate_b   = pin_s_q[`SSS_PIN_GATE_B];

	// apb decode: one wait state, write takes effect when pready is sampled
	wire       acc      = psel && penable && !pready_q;
	wire       wr       = psel && penable && pready_q && pwrite;
	wire [5:0] idx      = paddr[7:2];
	wire       hit_hard_reset_request = (idx == `SSS_IDX_HARD_RESET_REQUEST);
	wire       hit_restart_request = (idx == `SSS_IDX_RESTART_REQUEST);
	wire       hit_st   = (idx == `SSS_IDX_STATE);
	wire       hit_ist  = (idx == `SSS_IDX_IRQ_ST);
	wire       hit_msk  = (idx == `SSS_IDX_IRQ_MSK);
	wire       mapped   = hit_hard_reset_request || hit_restart_request || hit_st || hit_ist || hit_msk;
	wire       err_w    = !mapped || (pwrite && hit_st);
	wire [7:0] wbyte    = pwdata[7:0];
	wire [1:0] wsel     = pwdata[`SSS_SEL_MSB:`SSS_SEL_LSB];

	// read data of each register, unused bits read zero
	wire [31:0] rd_hard_reset_request = 32'({hard_reset_request_hist_q, 1'b0, hard_reset_request_sel_q, 3'h0, hard_reset_request_q});
	wire [31:0] rd_restart_request = 32'({restart_request_hist_q, 1'b0, restart_request_sel_q, 3'h0, restart_request_q});
	wire [31:0] rd_st   = 32'({otp_s, 1'b0, running_q});
	wire [31:0] rd_w    = hit_hard_reset_request ? rd_hard_reset_request : hit_restart_request ? rd_restart_request : hit_st ? rd_st :
		hit_ist ? 32'(irq_st_q) : hit_msk ? 32'(irq_msk_q) : 32'h0;

	// apb answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= acc;
			prdata_q  <= (acc && !pwrite && !err_w) ? rd_w : 32'h0;
			pslverr_q <= acc && err_w;
		end
	end

	// hard reset request: a one starts the hold, a later one is ignored while busy
	wire hard_reset_request_wr   = wr && hit_hard_reset_request;
	wire hard_reset_request_go   = hard_reset_request_wr && wbyte[`SSS_GO_BIT] && !hard_reset_request_q;
	wire hard_reset_request_hold = hard_reset_request_go || (hold_t.busy && !hold_t.done);
	wire hard_reset_request_clr  = hard_reset_request_wr && (wbyte == `SSS_CLR_VAL);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hard_reset_request_q      <= 1'b0;
			hard_reset_request_sel_q  <= 2'h0;
			hard_reset_request_hist_q <= 1'b0;
		end else begin
			if (hard_reset_request_wr)
				hard_reset_request_sel_q <= wsel;
			hard_reset_request_q      <= hard_reset_request_go || (hard_reset_request_q && !hold_t.done);
			hard_reset_request_hist_q <= hard_reset_request_go || (hard_reset_request_hist_q && !hard_reset_request_clr);
		end
	end
	assign hold_t.start = hard_reset_request_go;
	assign hold_t.clr   = 1'b0;
	assign hold_t.load  = sel_cyc(wsel);

	// restart request: only a zero-to-one change triggers
	wire       restart_request_wr  = wr && hit_restart_request;
	wire       restart_request_go  = restart_request_wr && wbyte[`SSS_GO_BIT] && !restart_request_q;
	wire       restart_request_end = (state_q == ST_REWAIT) && seq_t.done;
	wire       restart_request_clr = restart_request_wr && (wbyte == `SSS_CLR_VAL);
	wire [1:0] restart_request_sel = restart_request_wr ? wsel : restart_request_sel_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restart_request_q      <= 1'b0;
			restart_request_sel_q  <= 2'h0;
			restart_request_hist_q <= 1'b0;
		end else begin
			if (restart_request_wr)
				restart_request_sel_q <= wsel;
			restart_request_q      <= restart_request_go || (restart_request_q && !restart_request_end);
			restart_request_hist_q <= restart_request_go || (restart_request_hist_q && !restart_request_clr);
		end
	end

	// start and stop conditions
	wire stop_c   = sup_lo_s || !en_s || otp_s || restart_request_go;
	wire start_ok = sup_hi_s && en_s && !otp_s && !restart_request_q;

	// sequencer: one step per timer expiry, any stop condition aborts start
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_OFF: begin
				if (restart_request_go)
					state_d = ST_REWAIT;
				else if (start_ok)
					state_d = ST_UP1;
			end
			ST_UP1, ST_UP2, ST_UP3, ST_UP4, ST_UP5: begin
				if (stop_c)
					state_d = ST_DN1;
				else if (seq_t.done)
					state_d = sss_state_e'(state_q + 4'h1);
			end
			ST_RUN: begin
				if (stop_c)
					state_d = ST_DN1;
			end
			ST_DN1, ST_DN2, ST_DN3, ST_DN4: begin
				if (seq_t.done)
					state_d = sss_state_e'(state_q + 4'h1);
			end
			ST_DN5: begin
				if (seq_t.done)
					state_d = restart_request_q ? ST_REWAIT : ST_OFF;
			end
			ST_REWAIT: begin
				if (seq_t.done)
					state_d = ST_OFF;
			end
			default: state_d = ST_OFF;
		endcase
	end

	// step timer: release delay, off time or stop-step delay
	wire seq_new = (state_d != state_q) && (state_d != ST_OFF) && (state_d != ST_RUN);
	assign seq_t.start = seq_new;
	assign seq_t.clr   = 1'b0;
	assign seq_t.load  = (state_d == ST_UP5) ? 32'(T_RRST_CYC) :
		(state_d == ST_REWAIT) ? sel_cyc(restart_request_sel) : 32'(T_STEP_CYC);

	// rail enables; while stopping a rail other than ldo_en[3] only ever turns off (ldo_en[3] turns on in ST_DN1 if gate a held it off)
	wire is_dn  = in_rng(state_d, ST_DN1, ST_DN5);
	wire run_d  = (state_d == ST_RUN);
	wire bb_d   = in_rng(state_d, ST_UP1, ST_DN4) && (!is_dn || bb_q);
	wire bk_d   = in_rng(state_d, ST_UP2, ST_DN3) && (!is_dn || bk_q);
	wire r1_d   = in_rng(state_d, ST_UP3, ST_DN2) && (!is_dn || r1_q);
	wire l4st_d = in_rng(state_d, ST_UP4, ST_DN1) && (!is_dn || l4st_q);
	wire r2_d   = run_d && !hard_reset_request_hold;
	wire both_d = r1_d && r2_d;
	wire l4_d   = l4st_d && (!both_d || gate_a);
	wire lo_d   = both_d && gate_a && gate_b;

	// output flops of the rails and resets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= ST_OFF;
			bb_q      <= 1'b0;
			bk_q      <= 1'b0;
			r1_q      <= 1'b0;
			r2_q      <= 1'b0;
			l4st_q    <= 1'b0;
			ldo_q     <= 4'h0;
			running_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			bb_q      <= bb_d;
			bk_q      <= bk_d;
			r1_q      <= r1_d;
			r2_q      <= r2_d;
			l4st_q    <= l4st_d;
			ldo_q     <= {l4_d, {3{lo_d}}};
			running_q <= run_d;
		end
	end

	// short qualification: the timer restarts on each new short and aborts on release
	assign sc_t.start = short_s && !sc_t.busy && !sc_seen_q;
	assign sc_t.clr   = !short_s;
	assign sc_t.load  = 32'(T_SHORT_CYC);
	wire sc_ev = sc_t.done && short_s;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc_seen_q  <= 1'b0;
			otp_prev_q <= 1'b0;
		end else begin
			sc_seen_q  <= short_s && (sc_seen_q || sc_ev);
			otp_prev_q <= otp_s;
		end
	end

	// interrupt: sticky events, write one to clear, set wins
	wire [`SSS_EV_W-1:0] ev;
	assign ev[`SSS_EV_UP]    = run_d && (state_q != ST_RUN);
	assign ev[`SSS_EV_DOWN]  = (state_q == ST_DN5) && seq_t.done;
	assign ev[`SSS_EV_SHORT] = sc_ev;
	assign ev[`SSS_EV_OTP]   = otp_s && !otp_prev_q;
	wire [`SSS_EV_W-1:0] w1c   = (wr && hit_ist) ? pwdata[`SSS_EV_W-1:0] : '0;
	wire [`SSS_EV_W-1:0] ist_d = ev | (irq_st_q & ~w1c);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_q  <= '0;
			irq_msk_q <= '0;
			irq_q     <= 1'b0;
		end else begin
			irq_st_q <= ist_d;
			if (wr && hit_msk)
				irq_msk_q <= pwdata[`SSS_EV_W-1:0];
			irq_q <= |(ist_d & irq_msk_q);
		end
	end

	// delay timers
	sss_timer u_seq_tmr (.pclk(pclk), .presetn(presetn), .t(seq_t.tmr));
	sss_timer u_hold_tmr (.pclk(pclk), .presetn(presetn), .t(hold_t.tmr));
	sss_timer u_sc_tmr (.pclk(pclk), .presetn(presetn), .t(sc_t.tmr));

	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign buckboost_en     = bb_q;
	assign buck_en          = {2{bk_q}};
	assign ldo_en           = ldo_q;
	assign reset_out_first  = r1_q;
	assign reset_out_second = r2_q;
	assign irq              = irq_q;

	// helper counters for the checks below
	sss_cnt_t st_cyc_q;
	sss_cnt_t short_run_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_cyc_q    <= '0;
			short_run_q <= '0;
		end else begin
			st_cyc_q    <= (state_d != state_q) ? 32'h0 : st_cyc_q + 32'h1;
			short_run_q <= short_s ? short_run_q + 32'h1 : 32'h0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_start_cond: assert property ((state_q == ST_OFF && state_d == ST_UP1) |->
		sup_hi_s && en_s) else $error("start without supply or enable");
	a_stop_entry: assert property ((state_q == ST_RUN && (sup_lo_s || !en_s)) |=>
		state_q == ST_DN1) else $error("no stop on supply low or enable low");
	a_restart_request_stop: assert property ((state_q == ST_RUN && restart_request_go) |=>
		state_q == ST_DN1) else $error("restart write did not stop");
	a_otp_stop: assert property ((otp_s && state_q == ST_UP3) |=>
		state_q == ST_DN1) else $error("over-temperature did not stop");
	a_run_flag: assert property (running_q == (state_q == ST_RUN))
		else $error("running flag differs from state");
	a_rrst_delay: assert property ((state_q == ST_UP5 && state_d == ST_RUN) |->
		st_cyc_q == 32'(T_RRST_CYC - 1)) else $error("release delay wrong");
	a_stop_step: assert property ((state_q == ST_DN1 && state_d == ST_DN2) |->
		st_cyc_q == 32'(T_STEP_CYC - 1)) else $error("stop step delay wrong");
	a_ldo_gate: assert property ((|ldo_en[2:0]) |->
		reset_out_first && reset_out_second && $past(gate_a && gate_b))
		else $error("linear regulators on without gate or resets");
	a_short_qual: assert property (sc_ev |-> short_run_q == 32'(T_SHORT_CYC))
		else $error("short declared early");
	a_hard_reset_request_hold: assert property (hold_t.busy |-> !reset_out_second)
		else $error("second reset high during hard reset");
	a_restart_request_clear: assert property ((state_q == ST_REWAIT && seq_t.done) |=>
		!restart_request_q && state_q == ST_OFF) else $error("restart bit not cleared");
	a_off_time: assert property ((state_q == ST_REWAIT && state_d == ST_OFF) |->
		st_cyc_q == sel_cyc(restart_request_sel_q) - 32'h1) else $error("off time wrong");
	a_hard_reset_request_clear: assert property ($fell(hold_t.busy) |-> !hard_reset_request_q)
		else $error("hard reset bit not cleared");
	a_gate_a_off: assert property ((|ldo_en) && reset_out_second |-> $past(gate_a))
		else $error("regulator on with gate a low");
	a_seq_order: assert property ($rose(reset_out_first) |-> buckboost_en &&
		(&buck_en) && !reset_out_second) else $error("first reset out of order");
	a_rst_off: assert property ((state_q == ST_OFF) |->
		!reset_out_first && !reset_out_second) else $error("reset high while stopped");

	c_run: cover property (state_q == ST_UP5 ##1 state_q == ST_RUN);
	c_restart: cover property (state_q == ST_DN5 ##1 state_q == ST_REWAIT);
	c_hard_reset_request: cover property (hard_reset_request_go && state_q == ST_RUN);
	c_short: cover property (sc_ev);
endmodule

// [supply_start_stop_sequencer_test.sv]
// self-checking bench of the supply start/stop sequencer
`timescale 1ns/100ps
module supply_start_stop_sequencer_test;
	import sss_pkg::*;
	localparam int STEP = 4;
	localparam int RRST = 20;
	localparam int MSC  = 10;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sup_hi;
	logic        sup_lo;
	logic        hot;
	logic        shorted;
	logic        want_on;
	logic        want_a;
	logic        want_b;
	logic        en_pin;
	logic        gate_a;
	logic        gate_b;
	logic        boost;
	logic [1:0]  buck;
	logic [3:0]  ldo;
	logic        rst1;
	logic        rst2;
	logic        irq;
	logic        alive;
	logic [5:0]  obs;
	logic [31:0] rd;
	logic        er;
	int          err_total;
	int          total_checks;
	int          n;
	int          hold;
	// watched outputs, indexed by the wait task
	assign obs = {irq, alive, ldo[3], rst2, rst1, boost};
	sss_top #(.T_STEP_CYC(STEP), .T_RRST_CYC(RRST), .T_SHORT_CYC(30), .T_MS_CYC(MSC)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chip_enable_in(en_pin),
		.supply_above_start(sup_hi), .supply_below_stop(sup_lo), .overtemp_in(hot),
		.output_short_in(shorted), .regulator_gate_in_a(gate_a),
		.regulator_gate_in_b(gate_b), .buckboost_en(boost), .buck_en(buck),
		.ldo_en(ldo), .reset_out_first(rst1), .reset_out_second(rst2), .irq(irq));
	sss_host_model host (
		.pclk(pclk), .presetn(presetn), .want_on(want_on), .want_a(want_a),
		.want_b(want_b), .reset_out_first(rst1), .reset_out_second(rst2),
		.chip_enable_in(en_pin), .regulator_gate_in_a(gate_a),
		.regulator_gate_in_b(gate_b), .host_alive(alive));
	// closing report
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k == 50) begin
			err_total++;
			stop_test();
		end
	endtask
	// waits for a watched output to reach a level, n counts the edges
	task automatic wait_bit(input int idx, input logic v);
		for (n = 0; n < 3000; n++) begin
			if (obs[idx] === v) break;
			@(posedge pclk);
		end
		if (n == 3000) begin
			err_total++;
			stop_test();
		end
	endtask
	// 250 mhz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{sup_hi, sup_lo, hot, shorted, want_a, want_b} = '0;
		want_on = 1'b1;
		err_total = 0;
		total_checks = 0;
		repeat (10) @(posedge pclk);
		check(32'({rst1, rst2, boost, ldo}), 32'h0);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		check(32'(boost), 32'h0);
		sup_hi <= 1'b1;
		wait_bit(1, 1'b1);
		check(32'({boost, buck, ldo[3]}), 32'he);
		wait_bit(3, 1'b1);
		wait_bit(2, 1'b1);
		check(32'(n >= RRST && n <= RRST + STEP + 2), 32'h1);
		// every gate pin combination while both resets are released
		for (int g = 0; g < 4; g++) begin
			want_a <= g[1];
			want_b <= g[0];
			repeat (6) @(posedge pclk);
			check(32'(ldo), (g == 3) ? 32'hf : (g == 2) ? 32'h8 : 32'h0);
		end
		apb(1'b0, 8'h14, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		check(rd & 32'h1, 32'h1);
		check(32'(irq), 32'h0);
		apb(1'b1, 8'h24, 32'h1);
		repeat (2) @(posedge pclk);
		check(32'(irq), 32'h1);
		apb(1'b1, 8'h20, 32'h1);
		repeat (2) @(posedge pclk);
		check(32'(irq), 32'h0);
		// hard reset with every hold code
		for (int s = 0; s < 4; s++) begin
			hold = MSC * ((s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 16);
			apb(1'b1, 8'h0c, 32'(s << 4) | 32'h1);
			@(posedge pclk);
			check(32'({rst2, rst1}), 32'h1);
			wait_bit(2, 1'b1);
			check(32'(n >= hold - 3 && n <= hold + 1), 32'h1);
			apb(1'b0, 8'h0c, 32'h0);
			check(rd, 32'(s << 4) | 32'h80);
		end
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		check(rd, 32'h0);
		// restart with the 4 ms code
		apb(1'b1, 8'h10, 32'h11);
		wait_bit(2, 1'b0);
		wait_bit(3, 1'b0);
		check(32'(n >= STEP - 1 && n <= STEP + 1), 32'h1);
		check(32'(rst1), 32'h1);
		wait_bit(0, 1'b0);
		wait_bit(0, 1'b1);
		// last stop step, off time, then one decision cycle in the off state
		check(32'(n >= 4 * MSC + STEP && n <= 4 * MSC + STEP + 1), 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		check(rd & 32'h1, 32'h0);
		wait_bit(2, 1'b1);
		// stop by the enable pin
		want_on <= 1'b0;
		wait_bit(0, 1'b0);
		check(32'({rst1, rst2, ldo}), 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		check(rd & 32'h2, 32'h2);
		// over-temperature stops and blocks start
		want_on <= 1'b1;
		wait_bit(2, 1'b1);
		hot <= 1'b1;
		wait_bit(0, 1'b0);
		apb(1'b0, 8'h14, 32'h0);
		check(rd, 32'h4);
		repeat (30) @(posedge pclk);
		check(32'(boost), 32'h0);
		hot <= 1'b0;
		wait_bit(2, 1'b1);
		// supply falling to the stop level
		sup_lo <= 1'b1;
		sup_hi <= 1'b0;
		wait_bit(0, 1'b0);
		check(32'(alive), 32'h0);
		// short qualification: too brief, then long enough
		shorted <= 1'b1;
		repeat (20) @(posedge pclk);
		shorted <= 1'b0;
		apb(1'b0, 8'h20, 32'h0);
		check(rd & 32'h4, 32'h0);
		shorted <= 1'b1;
		repeat (40) @(posedge pclk);
		apb(1'b0, 8'h20, 32'h0);
		check(rd & 32'h4, 32'h4);
		// refused accesses
		apb(1'b0, 8'h1c, 32'h0);
		check(32'(er), 32'h1);
		apb(1'b1, 8'h14, 32'h1);
		check(32'(er), 32'h1);
		stop_test();
	end
endmodule
